/* rtl/sfc_host.v */
// host controller that drives a serial flash over its pins
// Function
// - msb first on rising clocks; select never rises inside a byte
// - high speed read: 0BH, 24 address bits, dummy byte, one line
// - chip select stays low over the read; data follows the dummy cycle
// - dual output read sends 3BH, address and dummy byte on io line 0
// - dual io read: BBH single, then address and dummy two bits a clock
// - dual address: odd bits on io line 1, even on io line 0, same edge
// - host releases both io lines during the dual io dummy clocks
// - page program: 02H, three address bytes, data, then select high
// - host must only program bytes already erased to all ones
// - sector erase uses 20H or D7H plus address; bits 12 up pick sector
// - block erase uses D8H plus address; bits 16 up pick the block
// - chip erase uses 60H or C7H with no address
// - host sends write enable in its own frame before program or erase
// - program and erase start on chip select rising after the last bit
// - program and erase are self timed; host waits the operation time
`include "sfc_map.vh"

module sfc_host #(
  parameter        LEN_W          = 16,
  parameter [7:0]  SCK_HALF       = `SFC_SCK_HALF_CYC,
  parameter [31:0] CS_HIGH_CYC    = `SFC_CS_HIGH_CYC,
  parameter [31:0] PAGE_WRITE_CYC = `SFC_US_TO_CYC(`SFC_PAGE_WRITE_TIME_US),
  parameter [31:0] SECT_ERASE_CYC =
    `SFC_US_TO_CYC(`SFC_SECTOR_ERASE_TIME_US),
  parameter [31:0] BLK_ERASE_CYC  = `SFC_US_TO_CYC(`SFC_BLOCK_ERASE_TIME_US),
  parameter [31:0] FULL_ERASE_CYC = `SFC_US_TO_CYC(`SFC_FULL_ERASE_TIME_US)
) (
  // clock and reset
  input  wire             clk,
  input  wire             resetn,
  // command port
  input  wire             cmdValid,
  output reg              cmdReady,
  input  wire [2:0]       cmdOp,
  input  wire             cmdAlt,
  input  wire [23:0]      cmdAddr,
  input  wire [LEN_W-1:0] cmdLen,
  // program data in
  input  wire             wrValid,
  output reg              wrReady,
  input  wire [7:0]       wrData,
  // read data out
  output wire             rdValid,
  input  wire             rdReady,
  output wire [7:0]       rdData,
  // status
  output reg              busy,
  output reg              done,
  // flash pins
  output reg              csN,
  output reg              sck,
  output reg              io0Out,
  output reg              io0Oe,
  input  wire             io0In,
  output reg              io1Out,
  output reg              io1Oe,
  input  wire             io1In
);

  // =======================================================
  // states
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_WEN   = 4'h1;
  localparam [3:0] S_GAP   = 4'h2;
  localparam [3:0] S_CMD   = 4'h3;
  localparam [3:0] S_ADDR  = 4'h4;
  localparam [3:0] S_DUMMY = 4'h5;
  localparam [3:0] S_RDATA = 4'h6;
  localparam [3:0] S_WLOAD = 4'h7;
  localparam [3:0] S_WDATA = 4'h8;
  localparam [3:0] S_END   = 4'h9;
  localparam [3:0] S_BUSY  = 4'hA;

  localparam [LEN_W-1:0] LEN_ONE = 1;

  reg  [3:0]       state_r,  state_nxt;
  reg  [31:0]      txSr_r,   txSr_nxt;
  reg              dual_r,   dual_nxt;
  reg  [5:0]       bits_r,   bits_nxt;
  reg  [LEN_W-1:0] len_r,    len_nxt;
  reg  [2:0]       op_r,     op_nxt;
  reg              alt_r,    alt_nxt;
  reg  [23:0]      addr_r,   addr_nxt;
  reg  [7:0]       rxSr_r,   rxSr_nxt;
  reg  [7:0]       div_r,    div_nxt;
  reg  [31:0]      tmr_r,    tmr_nxt;
  reg              finish_r, finish_nxt;
  reg              push_r,   push_nxt;
  reg  [7:0]       pushD_r,  pushD_nxt;
  reg              sck_nxt,  csN_nxt;
  reg              cmdReady_nxt, wrReady_nxt, busy_nxt, done_nxt;
  reg              io0Oe_nxt, io1Oe_nxt;
  reg              io0Meta_r, io0Sync_r, io1Meta_r, io1Sync_r;
  wire             bufInReady;
  wire             isWrite, isRead, dualData, tick, stall, running;
  reg  [7:0]       opcode;
  reg  [31:0]      opTime;

  // =======================================================
  // pin inputs pass two flops; half period must be at least
  // three cycles so the synced value has settled at the rise
  always @(posedge clk) begin
    if (!resetn) begin
      io0Meta_r <= 1'b0;
      io0Sync_r <= 1'b0;
      io1Meta_r <= 1'b0;
      io1Sync_r <= 1'b0;
    end else begin
      io0Meta_r <= io0In;
      io0Sync_r <= io0Meta_r;
      io1Meta_r <= io1In;
      io1Sync_r <= io1Meta_r;
    end
  end

  // =======================================================
  // operation decode
  assign isWrite  = (op_r >= `SFC_OP_PAGE_PROG);
  assign isRead   = ~isWrite;
  assign dualData = (op_r != `SFC_OP_HS_READ);

  // opcode and wait time for the captured operation
  always @* begin
    case (op_r)
      `SFC_OP_HS_READ:     opcode = `SFC_OPC_HS_READ;
      `SFC_OP_DUAL_OUT:    opcode = `SFC_OPC_DUAL_OUT;
      `SFC_OP_DUAL_IO:     opcode = `SFC_OPC_DUAL_IO;
      `SFC_OP_PAGE_PROG:   opcode = `SFC_OPC_PAGE_PROG;
      `SFC_OP_SECT_ERASE:  opcode = alt_r ? `SFC_OPC_SECT_ERASE_ALT
                                          : `SFC_OPC_SECT_ERASE;
      `SFC_OP_BLOCK_ERASE: opcode = `SFC_OPC_BLOCK_ERASE;
      `SFC_OP_CHIP_ERASE:  opcode = alt_r ? `SFC_OPC_CHIP_ERASE_ALT
                                          : `SFC_OPC_CHIP_ERASE;
      default:             opcode = `SFC_OPC_HS_READ;
    endcase
    case (op_r)
      `SFC_OP_PAGE_PROG:   opTime = PAGE_WRITE_CYC;
      `SFC_OP_SECT_ERASE:  opTime = SECT_ERASE_CYC;
      `SFC_OP_BLOCK_ERASE: opTime = BLK_ERASE_CYC;
      default:             opTime = FULL_ERASE_CYC;
    endcase
  end

  // =======================================================
  // serial clock divider; a full receive buffer freezes the
  // clock just before the last rise of a byte, so no word is lost
  assign running = (state_r == S_WEN)   || (state_r == S_CMD)   ||
                   (state_r == S_ADDR)  || (state_r == S_DUMMY) ||
                   (state_r == S_RDATA) || (state_r == S_WDATA);
  assign tick    = running && (div_r == SCK_HALF - 8'h01);
  assign stall   = (state_r == S_RDATA) && !sck && (bits_r == 6'h01) &&
                   !bufInReady;

  // =======================================================
  // next state and datapath
  always @* begin
    state_nxt    = state_r;
    txSr_nxt     = txSr_r;
    dual_nxt     = dual_r;
    bits_nxt     = bits_r;
    len_nxt      = len_r;
    op_nxt       = op_r;
    alt_nxt      = alt_r;
    addr_nxt     = addr_r;
    rxSr_nxt     = rxSr_r;
    div_nxt      = div_r;
    tmr_nxt      = tmr_r;
    finish_nxt   = finish_r;
    push_nxt     = 1'b0;
    pushD_nxt    = pushD_r;
    sck_nxt      = sck;
    csN_nxt      = csN;
    cmdReady_nxt = cmdReady;
    wrReady_nxt  = 1'b0;
    busy_nxt     = busy;
    done_nxt     = 1'b0;
    if (running && !tick) begin
      div_nxt = div_r + 8'h01;
    end else if (tick && !stall) begin
      div_nxt = 8'h00;
      if (!sck) begin
        // rising edge: the device samples here, we sample its data
        sck_nxt = 1'b1;
        if (state_r == S_RDATA) begin
          rxSr_nxt = dualData ? {rxSr_r[5:0], io1Sync_r, io0Sync_r}
                              : {rxSr_r[6:0], io1Sync_r};
          if (bits_r == 6'h01) begin
            push_nxt  = 1'b1;
            pushD_nxt = rxSr_nxt;
          end
        end
      end else begin
        // falling edge: next bit goes out, msb first
        sck_nxt  = 1'b0;
        bits_nxt = bits_r - 6'h01;
        txSr_nxt = dual_r ? {txSr_r[29:0], 2'b00}
                          : {txSr_r[30:0], 1'b0};
        if (bits_r == 6'h01) begin
          // phase ends only after its last whole bit
          case (state_r)
            S_WEN: begin
              // select rises a cycle after this last fall, never with it
              state_nxt = S_GAP;
              tmr_nxt   = CS_HIGH_CYC + 32'h0000_0001;
            end
            S_CMD: begin
              if (op_r == `SFC_OP_CHIP_ERASE) begin
                state_nxt = S_END;
              end else begin
                state_nxt = S_ADDR;
                txSr_nxt  = {addr_r, 8'h00};
                dual_nxt  = (op_r == `SFC_OP_DUAL_IO);
                bits_nxt  = dual_nxt ? `SFC_CLKS_ADDR_DUAL
                                     : `SFC_CLKS_ADDR;
              end
            end
            S_ADDR: begin
              txSr_nxt = 32'h0000_0000;
              if (isRead) begin
                state_nxt = S_DUMMY;
                bits_nxt  = dual_r ? `SFC_CLKS_BYTE_DUAL : `SFC_CLKS_BYTE;
              end else if (op_r == `SFC_OP_PAGE_PROG) begin
                state_nxt = S_WLOAD;
                dual_nxt  = 1'b0;
              end else begin
                state_nxt = S_END;
              end
            end
            S_DUMMY: begin
              state_nxt = S_RDATA;
              dual_nxt  = 1'b0;
              bits_nxt  = dualData ? `SFC_CLKS_BYTE_DUAL : `SFC_CLKS_BYTE;
            end
            S_RDATA: begin
              if (len_r == {LEN_W{1'b0}}) begin
                state_nxt = S_END;
              end else begin
                len_nxt  = len_r - LEN_ONE;
                bits_nxt = dualData ? `SFC_CLKS_BYTE_DUAL : `SFC_CLKS_BYTE;
              end
            end
            S_WDATA: begin
              if (len_r == {LEN_W{1'b0}}) begin
                state_nxt = S_END;
              end else begin
                len_nxt   = len_r - LEN_ONE;
                state_nxt = S_WLOAD;
              end
            end
            default: state_nxt = S_END;
          endcase
        end
      end
    end
    case (state_r)
      S_IDLE: begin
        cmdReady_nxt = 1'b1;
        if (cmdValid && cmdReady) begin
          cmdReady_nxt = 1'b0;
          busy_nxt     = 1'b1;
          op_nxt       = cmdOp;
          alt_nxt      = cmdAlt;
          addr_nxt     = cmdAddr;
          len_nxt      = cmdLen;
          finish_nxt   = 1'b0;
          csN_nxt      = 1'b0;
          dual_nxt     = 1'b0;
          bits_nxt     = `SFC_CLKS_BYTE;
          div_nxt      = 8'h00;
          if (cmdOp >= `SFC_OP_PAGE_PROG) begin
            state_nxt = S_WEN;
            txSr_nxt  = {`SFC_OPC_WRITE_ENABLE, 24'h000000};
          end else begin
            state_nxt = S_CMD;
            txSr_nxt  = {opcodeOf(cmdOp, cmdAlt), 24'h000000};
          end
        end
      end
      S_GAP: begin
        // chip select stays high for its least time between frames
        if (tmr_r > 32'h0000_0001) begin
          tmr_nxt = tmr_r - 32'h0000_0001;
          csN_nxt = 1'b1;
        end else if (finish_r) begin
          state_nxt = S_IDLE;
          busy_nxt  = 1'b0;
          done_nxt  = 1'b1;
        end else begin
          state_nxt = S_CMD;
          csN_nxt   = 1'b0;
          txSr_nxt  = {opcode, 24'h000000};
          bits_nxt  = `SFC_CLKS_BYTE;
          div_nxt   = 8'h00;
        end
      end
      S_WLOAD: begin
        // one data byte per handshake; the clock waits for it
        wrReady_nxt = !(wrValid && wrReady);
        if (wrValid && wrReady) begin
          state_nxt = S_WDATA;
          txSr_nxt  = {wrData, 24'h000000};
          bits_nxt  = `SFC_CLKS_BYTE;
          div_nxt   = 8'h00;
        end
      end
      S_END: begin
        csN_nxt    = 1'b1;
        finish_nxt = 1'b1;
        if (isWrite) begin
          state_nxt = S_BUSY;
          tmr_nxt   = opTime;
        end else begin
          state_nxt = S_GAP;
          tmr_nxt   = CS_HIGH_CYC;
        end
      end
      S_BUSY: begin
        // no status polling here, so wait the full operation time
        if (tmr_r > 32'h0000_0001) begin
          tmr_nxt = tmr_r - 32'h0000_0001;
        end else begin
          state_nxt = S_IDLE;
          busy_nxt  = 1'b0;
          done_nxt  = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // line drivers follow the next state; io lines are released
    // through the dual io dummy and all read data clocks
    io0Oe_nxt = (state_nxt == S_WEN)   || (state_nxt == S_CMD)   ||
                (state_nxt == S_ADDR)  || (state_nxt == S_WLOAD) ||
                (state_nxt == S_WDATA) ||
                (state_nxt == S_DUMMY && op_r != `SFC_OP_DUAL_IO);
    io1Oe_nxt = (state_nxt == S_ADDR) && dual_nxt;
  end

  // opcode lookup for a command not yet captured
  function [7:0] opcodeOf;
    input [2:0] op;
    input       alt;
    begin
      case (op)
        `SFC_OP_HS_READ:  opcodeOf = `SFC_OPC_HS_READ;
        `SFC_OP_DUAL_OUT: opcodeOf = `SFC_OPC_DUAL_OUT;
        `SFC_OP_DUAL_IO:  opcodeOf = `SFC_OPC_DUAL_IO;
        default:          opcodeOf = alt ? `SFC_OPC_CHIP_ERASE_ALT
                                         : `SFC_OPC_CHIP_ERASE;
      endcase
    end
  endfunction

  // =======================================================
  // registers
  always @(posedge clk) begin
    if (!resetn) begin
      state_r  <= S_IDLE;
      txSr_r   <= 32'h0000_0000;
      dual_r   <= 1'b0;
      bits_r   <= 6'h00;
      len_r    <= {LEN_W{1'b0}};
      op_r     <= 3'h0;
      alt_r    <= 1'b0;
      addr_r   <= 24'h000000;
      rxSr_r   <= 8'h00;
      div_r    <= 8'h00;
      tmr_r    <= 32'h0000_0000;
      finish_r <= 1'b0;
      push_r   <= 1'b0;
      pushD_r  <= 8'h00;
      cmdReady <= 1'b0;
      wrReady  <= 1'b0;
      busy     <= 1'b0;
      done     <= 1'b0;
      csN      <= 1'b1;
      sck      <= 1'b0;
      io0Out   <= 1'b0;
      io0Oe    <= 1'b0;
      io1Out   <= 1'b0;
      io1Oe    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      txSr_r   <= txSr_nxt;
      dual_r   <= dual_nxt;
      bits_r   <= bits_nxt;
      len_r    <= len_nxt;
      op_r     <= op_nxt;
      alt_r    <= alt_nxt;
      addr_r   <= addr_nxt;
      rxSr_r   <= rxSr_nxt;
      div_r    <= div_nxt;
      tmr_r    <= tmr_nxt;
      finish_r <= finish_nxt;
      push_r   <= push_nxt;
      pushD_r  <= pushD_nxt;
      cmdReady <= cmdReady_nxt;
      wrReady  <= wrReady_nxt;
      busy     <= busy_nxt;
      done     <= done_nxt;
      csN      <= csN_nxt;
      sck      <= sck_nxt;
      io0Out   <= dual_nxt ? txSr_nxt[30] : txSr_nxt[31];
      io0Oe    <= io0Oe_nxt;
      io1Out   <= txSr_nxt[31];
      io1Oe    <= io1Oe_nxt;
    end
  end

  // =======================================================
  // read data buffer
  sfc_rx_buf #(
    .WIDTH (8),
    .DEPTH (2),
    .CW    (2)
  ) u_rx_buf (
    .clk      (clk),
    .resetn   (resetn),
    .inValid  (push_r),
    .inReady  (bufInReady),
    .inData   (pushD_r),
    .outValid (rdValid),
    .outReady (rdReady),
    .outData  (rdData)
  );

endmodule // sfc_host

/* pkg/sfc_map.vh */
// constants for the serial flash host controller
`ifndef SFC_MAP_VH
`define SFC_MAP_VH

// ==========================================================
// opcodes sent on the bus
`define SFC_OPC_WRITE_ENABLE   8'h06
`define SFC_OPC_HS_READ        8'h0B
`define SFC_OPC_DUAL_OUT       8'h3B
`define SFC_OPC_DUAL_IO        8'hBB
`define SFC_OPC_PAGE_PROG      8'h02
`define SFC_OPC_SECT_ERASE     8'h20
`define SFC_OPC_SECT_ERASE_ALT 8'hD7
`define SFC_OPC_BLOCK_ERASE    8'hD8
`define SFC_OPC_CHIP_ERASE     8'h60
`define SFC_OPC_CHIP_ERASE_ALT 8'hC7

// ==========================================================
// operation codes on the command port
`define SFC_OP_HS_READ     3'h0
`define SFC_OP_DUAL_OUT    3'h1
`define SFC_OP_DUAL_IO     3'h2
`define SFC_OP_PAGE_PROG   3'h3
`define SFC_OP_SECT_ERASE  3'h4
`define SFC_OP_BLOCK_ERASE 3'h5
`define SFC_OP_CHIP_ERASE  3'h6

// ==========================================================
// serial clocks per phase
`define SFC_CLKS_BYTE      6'h08
`define SFC_CLKS_BYTE_DUAL 6'h04
`define SFC_CLKS_ADDR      6'h18
`define SFC_CLKS_ADDR_DUAL 6'h0C

// ==========================================================
// timing: rate, serial clock divider, chip select gap, busy waits
`define SFC_CLK_MHZ            40
`define SFC_SCK_HALF_CYC       8'h04
`define SFC_CS_HIGH_NS         50
`define SFC_CS_HIGH_CYC        ((`SFC_CS_HIGH_NS*`SFC_CLK_MHZ+999)/1000)
`define SFC_PAGE_WRITE_TIME_US 1000
`define SFC_SECTOR_ERASE_TIME_US 50000
`define SFC_BLOCK_ERASE_TIME_US  100000
`define SFC_FULL_ERASE_TIME_US   1000000
`define SFC_US_TO_CYC(us)      ((us)*`SFC_CLK_MHZ)

`endif

/* rtl/sfc_rx_buf.v */
// small shift buffer between the serial receiver and the read data port
module sfc_rx_buf #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter CW    = 2
) (
  // clock and reset
  input  wire             clk,
  input  wire             resetn,
  // filling side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // draining side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);

  localparam [CW-1:0] FULL_CNT = DEPTH;
  localparam [CW-1:0] ONE      = 1;

  reg  [WIDTH-1:0] ent_r [0:DEPTH-1];
  reg  [CW-1:0]    count_r;
  reg              headValid_r;
  reg  [CW-1:0]    count_nxt;
  wire             push;
  wire             pop;

  // =======================================================
  // handshake
  assign inReady  = (count_r != FULL_CNT);
  assign push     = inValid & inReady;
  assign pop      = headValid_r & outReady;
  assign outValid = headValid_r;
  assign outData  = ent_r[0];   // head entry is a flop

  always @* begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + ONE;
    end else if (pop && !push) begin
      count_nxt = count_r - ONE;
    end
  end

  // occupancy and a registered copy of the head's valid
  always @(posedge clk) begin
    if (!resetn) begin
      count_r     <= {CW{1'b0}};
      headValid_r <= 1'b0;
    end else begin
      count_r     <= count_nxt;
      headValid_r <= (count_nxt != {CW{1'b0}});
    end
  end

  // =======================================================
  // entries shift toward the head on pop
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
      localparam [CW-1:0] IDX = i;
      wire [WIDTH-1:0] upper;
      if (i < DEPTH - 1) begin : g_up
        assign upper = ent_r[i+1];
      end else begin : g_top
        assign upper = ent_r[i];
      end
      always @(posedge clk) begin
        if (!resetn) begin
          ent_r[i] <= {WIDTH{1'b0}};
        end else if (pop) begin
          ent_r[i] <= (push && IDX == count_r - ONE) ? inData : upper;
        end else if (push && IDX == count_r) begin
          ent_r[i] <= inData;
        end
      end
    end
  endgenerate

endmodule // sfc_rx_buf

/* bench/sfc_flash_model.sv */
// behavioural flash device seen across the host controller pins
module sfc_flash_model (
  // pins driven by the host
  input  wire logic csN,
  input  wire logic sck,
  input  wire logic io0,
  input  wire logic io1,
  // device drive, released outside reads
  output logic      devQ0,
  output logic      devQ1,
  output logic      devOe0,
  output logic      devOe1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  op, sh, b;
  logic [23:0] a, p;
  logic        wel = 1'h0;
  int          prot = 0; // bytes below this are protected; none here
  int          n, k;
  logic [7:0]  mem [int];
  logic [7:0]  pg [$];
  wire dio  = op == 8'hBB;
  wire dual = dio || op == 8'h3B;
  initial {devQ0, devQ1, devOe0, devOe1} = 4'h0;
  // unwritten locations read as erased
  function automatic logic [7:0] rd(input logic [23:0] x);
    return mem.exists(x) ? mem[x] : 8'hFF;
  endfunction
  task automatic erase(input logic [23:0] base, input int len);
    for (int j = 0; j < len; j++)
      if (mem.exists(base + j)) mem.delete(base + j);
  endtask
  // ==========================================================
  // frame start and input sampling on rising sck
  always @(negedge csN) begin
    n = 0;
    pg.delete();
  end
  always @(posedge sck) if (!csN) begin
    if (n < 8) op = {op[6:0], io0};
    else if (dio && n < 20) a = {a[21:0], io1, io0};
    else if (!dio && n < 32) a = {a[22:0], io0};
    else if (op == 8'h02) begin
      sh = {sh[6:0], io0};
      if (n % 8 == 7) pg.push_back(sh);
      if (pg.size() > 256) void'(pg.pop_front());
    end
    n++;
  end
  // ==========================================================
  // read data leaves on falling sck once the dummy clocks are over
  always @(negedge sck) begin
    k = n - (dio ? 24 : 40);
    if (!csN && k >= 0 && (dual || op == 8'h0B)) begin
      b = rd(a + (dual ? k / 4 : k / 8));
      devOe1 = 1'h1;
      devOe0 = dual;
      devQ1 = dual ? b[7 - 2 * (k % 4)] : b[7 - k % 8];
      devQ0 = b[6 - 2 * (k % 4)];
    end
  end
  // ==========================================================
  // select rising ends a read and starts any write
  always @(posedge csN) begin
    devOe0 = 1'h0;
    devOe1 = 1'h0;
    if (n == 8 && op == 8'h06) wel = 1'h1;
    else if (wel && !dual && op != 8'h0B) begin
      case (op)
        8'h02: if (a >= prot) foreach (pg[i]) begin
          p = {a[23:8], a[7:0] + 8'(i)};
          mem[p] = pg[i] & rd(p);
        end
        8'h20, 8'hD7: if (n == 32 && a >= prot)
          erase(a & 24'hFFF000, 4096);
        8'hD8: if (n == 32 && a >= prot)
          erase(a & 24'hFF0000, 65536);
        8'h60, 8'hC7: if (n == 8 && prot == 0) mem.delete();
        default: ;
      endcase
      wel = 1'h0;
    end
  end
endmodule // sfc_flash_model

/* bench/sfc_host_chk.sv */
// port assertions for the flash host controller
`include "sfc_map.vh"
module sfc_host_chk #(
  parameter [7:0]  SCK_HALF    = 8'h04,
  parameter [31:0] CS_HIGH_CYC = 32'h2
) (
  // clock and reset
  input wire       clk,
  input wire       resetn,
  // command and read ports
  input wire       cmdValid,
  input wire       cmdReady,
  input wire [2:0] cmdOp,
  input wire       rdValid,
  input wire       rdReady,
  input wire [7:0] rdData,
  input wire       busy,
  input wire       done,
  // flash pins
  input wire       csN,
  input wire       sck,
  input wire       io0Out,
  input wire       io0Oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] hiCnt_r, gapCnt_r;
  // sck high length and select idle length; gap saturates
  always @(posedge clk) begin
    hiCnt_r <= (sck && resetn) ? hiCnt_r + 8'h01 : 8'h00;
    if (!resetn) gapCnt_r <= 8'hFF;
    else if (!csN) gapCnt_r <= 8'h00;
    else if (gapCnt_r != 8'hFF) gapCnt_r <= gapCnt_r + 8'h01;
  end
  sequence s_take;
    cmdValid && cmdReady;
  endsequence
  sequence s_sck_fall;
    $fell(sck);
  endsequence
  AST_TAKE_START: assert property (s_take |=>
    busy && !cmdReady && !csN) else $error("no frame after take");
  AST_FIRST_BIT: assert property (s_take |=> io0Oe &&
    io0Out == ($past(cmdOp) == `SFC_OP_DUAL_IO)) else $error("first bit");
  AST_SCK_IDLE: assert property (csN |-> !sck)
    else $error("sck runs while deselected");
  AST_SCK_HALF: assert property (s_sck_fall |-> hiCnt_r == SCK_HALF)
    else $error("sck high length");
  AST_IO_HOLD: assert property (sck && $past(sck) |->
    $stable(io0Out)) else $error("data moved while sck high");
  AST_CS_GAP: assert property ($fell(csN) |->
    gapCnt_r >= CS_HIGH_CYC) else $error("select gap short");
  AST_CS_END: assert property ($rose(csN) |-> !sck && !$past(sck))
    else $error("select rose mid bit");
  AST_DONE: assert property (done |-> !busy ##1 !done)
    else $error("done not a lone pulse");
  AST_BUSY_END: assert property ($fell(busy) |-> done && csN)
    else $error("busy ended without done");
  AST_RD_HOLD: assert property (rdValid && !rdReady |=>
    rdValid && $stable(rdData)) else $error("read byte lost");
endmodule // sfc_host_chk
bind sfc_host sfc_host_chk #(
  .SCK_HALF(SCK_HALF),
  .CS_HIGH_CYC(CS_HIGH_CYC)
) u_chk (
  .clk(clk), .resetn(resetn), .cmdValid(cmdValid), .cmdReady(cmdReady),
  .cmdOp(cmdOp), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData),
  .busy(busy), .done(done), .csN(csN), .sck(sck), .io0Out(io0Out),
  .io0Oe(io0Oe)
);

/* bench/sfc_host_tb_top.sv */
// self-checking bench for the flash host controller
`include "sfc_map.vh"
module sfc_host_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus, wiring, score
  logic        clk = 1'h0, resetn = 1'h0, cmdValid = 1'h0, cmdAlt = 1'h0;
  logic        wrValid = 1'h0, rdReady = 1'h1;
  logic [2:0]  cmdOp = 3'h0;
  logic [23:0] cmdAddr = 24'h0;
  logic [15:0] cmdLen = 16'h0;
  logic [7:0]  wrData = 8'h0;
  wire         cmdReady, wrReady, rdValid, busy, done, csN, sck;
  wire         io0Out, io0Oe, io1Out, io1Oe, q0, q1, oe0, oe1;
  wire [7:0]   rdData;
  int          fails = 0, num_checks = 0, cyc = 0;
  logic [7:0]  wq [$], got [$];
  // pull-ups hold released lines high
  wire io0 = io0Oe ? io0Out : (oe0 ? q0 : 1'h1);
  wire io1 = io1Oe ? io1Out : (oe1 ? q1 : 1'h1);
  always #12.5 clk = ~clk;
  sfc_host #(
    .PAGE_WRITE_CYC(32'h14), .SECT_ERASE_CYC(32'h14),
    .BLK_ERASE_CYC(32'h14), .FULL_ERASE_CYC(32'h14)
  ) i_dut (
    .clk(clk), .resetn(resetn), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOp(cmdOp), .cmdAlt(cmdAlt), .cmdAddr(cmdAddr), .cmdLen(cmdLen),
    .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .busy(busy),
    .done(done), .csN(csN), .sck(sck), .io0Out(io0Out), .io0Oe(io0Oe),
    .io0In(io0), .io1Out(io1Out), .io1Oe(io1Oe), .io1In(io1)
  );
  sfc_flash_model i_flash (
    .csN(csN), .sck(sck), .io0(io0), .io1(io1),
    .devQ0(q0), .devQ1(q1), .devOe0(oe0), .devOe1(oe1)
  );
  // ==========================================================
  // byte streams and hang guard
  always @(negedge clk) begin
    wrValid <= wq.size() != 0;
    wrData <= wq.size() ? wq[0] : 8'h00;
  end
  always @(posedge clk) begin
    if (wrValid && wrReady) void'(wq.pop_front());
    if (rdValid && rdReady) got.push_back(rdData);
    cyc++;
    if (cyc == 40000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one command, held until taken, then wait for completion
  task automatic run(input logic [2:0] op, input logic alt,
                     input logic [23:0] ad, input logic [15:0] ln);
    @(negedge clk);
    {cmdOp, cmdAlt, cmdAddr, cmdLen} = {op, alt, ad, ln};
    cmdValid = 1'h1;
    while (cmdReady !== 1'h1) @(negedge clk);
    @(negedge clk);
    cmdValid = 1'h0;
    while (done !== 1'h1) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reads;
    wq = '{8'hA5, 8'h3C, 8'h96};
    run(`SFC_OP_PAGE_PROG, 1'h0, 24'h0000FE, 16'h0002);
    rdReady = 1'h0;
    fork
      run(`SFC_OP_HS_READ, 1'h0, 24'h0000FE, 16'h0002);
      begin
        repeat (800) @(negedge clk);
        check({6'h00, rdValid, csN}, 8'h02);
        rdReady = 1'h1;
      end
    join
    check(got[0], 8'hA5);
    check(got[1], 8'h3C);
    check(got[2], 8'hFF);
    got.delete();
    run(`SFC_OP_DUAL_OUT, 1'h0, 24'h000000, 16'h0000);
    check(got[0], 8'h96);
    got.delete();
    run(`SFC_OP_DUAL_IO, 1'h0, 24'hFFFFFF, 16'h0001);
    check(got[0], 8'hFF);
    check(got[1], 8'h96);
  endtask
  task automatic t_erase;
    logic [2:0]  eop [5] = '{`SFC_OP_SECT_ERASE, `SFC_OP_SECT_ERASE,
      `SFC_OP_BLOCK_ERASE, `SFC_OP_CHIP_ERASE, `SFC_OP_CHIP_ERASE};
    logic        alt [5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
    logic [23:0] ead [5] = '{24'h000FFF, 24'h000FFF, 24'h00FFFF,
      24'h000000, 24'h000000};
    for (int i = 0; i < 5; i++) begin
      wq = '{8'h5A};
      run(`SFC_OP_PAGE_PROG, 1'h0, 24'h000010, 16'h0000);
      run(eop[i], alt[i], ead[i], 16'h0000);
      got.delete();
      run(`SFC_OP_HS_READ, 1'h0, 24'h000010, 16'h0000);
      check(got[0], 8'hFF);
    end
  endtask
  initial begin
    repeat (5) @(negedge clk);
    resetn = 1'h1;
    t_reads();
    t_erase();
    tally_and_finish();
  end
endmodule // sfc_host_tb_top
